/* rtl/hub_cfg_pkg.sv */
package hub_cfg_pkg;
	// Clock and timing
	localparam int CLK_MHZ           = 100;
	localparam int SUSPEND_IDLE_US   = 3000;
	localparam int SUSPEND_IDLE_CYC  = SUSPEND_IDLE_US * CLK_MHZ;
	localparam int LOW_POWER_US      = 7000;
	localparam int LOW_POWER_CYC     = LOW_POWER_US * CLK_MHZ;
	localparam int I2C_QUARTER_NS    = 2500;
	localparam int I2C_QUARTER_CYC   = (I2C_QUARTER_NS * CLK_MHZ) / 1000;
	// APB register map (byte addresses)
	localparam int          ADDR_W    = 8;
	localparam logic [7:0]  OFS_STAT  = 8'h00;
	localparam logic [7:0]  OFS_CTRL  = 8'h04;
	localparam logic [7:0]  OFS_IDS   = 8'h08;
	localparam logic [7:0]  OFS_INFO  = 8'h0C;
	// Control register fields
	localparam int CTRL_LED_EN  = 0;
	localparam int CTRL_RELOAD  = 1;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	// Status register fields
	localparam int STAT_MODE    = 0;
	localparam int STAT_CHRG    = 2;
	localparam int STAT_SELF    = 3;
	localparam int STAT_HOST    = 4;
	localparam int STAT_LOADED  = 5;
	localparam int STAT_VALID   = 6;
	localparam int STAT_NACK    = 7;
	localparam int STAT_SUSP    = 8;
	localparam int STAT_LOWPWR  = 9;
	localparam int STAT_PWREN_N = 10;
	// Hub topology reported upstream
	localparam logic [7:0] NUM_CONFIGS   = 8'h01;
	localparam logic [7:0] NUM_ENDPOINTS = 8'h02;
	// EEPROM image layout
	localparam int         IMG_BYTES   = 32;
	localparam logic [4:0] IMG_CHK0    = 5'h00;
	localparam logic [4:0] IMG_CHK1    = 5'h01;
	localparam logic [4:0] IMG_VID     = 5'h02;
	localparam logic [4:0] IMG_PID     = 5'h04;
	localparam logic [4:0] IMG_REL     = 5'h06;
	localparam logic [4:0] IMG_RSV0_LO = 5'h08;
	localparam logic [4:0] IMG_RSV0_HI = 5'h19;
	localparam logic [4:0] IMG_PORTS   = 5'h1A;
	localparam logic [4:0] IMG_RSV1_LO = 5'h1B;
	localparam logic [4:0] IMG_RSV1_HI = 5'h1E;
	localparam logic [4:0] IMG_SUM     = 5'h1F;
	localparam logic [7:0] CHK0_VAL    = 8'h40;
	localparam logic [7:0] CHK1_VAL    = 8'h1A;
	localparam logic [7:0] EEP_DEV_WR  = 8'hA0;
	localparam logic [7:0] EEP_DEV_RD  = 8'hA1;
	localparam logic [7:0] EEP_START   = 8'h00;
	// Defaults; identity values are arbitrary
	localparam logic [15:0] DEF_VID    = 16'h1234;
	localparam logic [15:0] DEF_PID    = 16'h5678;
	localparam logic [15:0] DEF_REL    = 16'h0100;
	localparam logic [7:0]  DEF_PORTS  = 8'h04;

	typedef enum logic [1:0] {
		MODE_SDP = 2'b00,
		MODE_CDP = 2'b01,
		MODE_DCP = 2'b10
	} mode_e;

	typedef enum logic [2:0] {
		I_IDLE  = 3'b000,
		I_START = 3'b001,
		I_WBIT  = 3'b010,
		I_WACK  = 3'b011,
		I_RBIT  = 3'b100,
		I_RACK  = 3'b101,
		I_STOP  = 3'b110,
		I_DONE  = 3'b111
	} i2c_e;
endpackage : hub_cfg_pkg

/* rtl/usb_hub_cfg_power.sv */
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/100ps
// What this block and the board do
// R01: Supply strap low means bus-powered, high means self-powered.
// R02: Charge strap sampled during reset; high permits downstream charging.
// R03: Power-up and external-pin resets both reset and latch the charge strap.
// R04: Downstream power enable low only when configured and no overcurrent.
// R05: Overcurrent input is active low and shared by all four ports.
// R06: Board holds test/serial-data line high for normal operation.
// R07: Suspend entry starts after 3 ms without upstream bus activity.
// R08: Bus-powered: cut upstream draw within 7 ms after suspend entry.
// R09: Self-powered charging stays active in every hub state, suspend included.
// R10: Charge high, host present, self-powered: charging downstream port mode.
// R11: Charge high, no host, self-powered: dedicated charging port mode.
// R12: Bus-powered with host present: standard port, no charging.
// R13: Charge strap low with host present: standard port mode.
// R14: One configuration with control and status-change endpoints reported.
// R15: Image accepted only when byte 0 is 0x40 and byte 1 is 0x1A.
// R16: Byte 0x1F holds bitwise checksum of bytes 0x00 to 0x1E.
// R17: Bad check, checksum or nonzero reserved byte selects default descriptors.
// R18: Vendor, product, release taken low byte first from bytes 2 to 7.
// R19: Byte 0x1A reported as downstream port count.
// R20: Charge strap pin drives active-high hub activity after reset.
// R21: External reset pin held low at least 10 us by the board.
// R22: Host sense high means an upstream host is connected.
// R23: Whole image loaded and checked before attaching upstream.
// R24: EEPROM that does not acknowledge is treated as an invalid image.
module usb_hub_cfg_power #(
	parameter int IDLE_CYC    = hub_cfg_pkg::SUSPEND_IDLE_CYC,
	parameter int QUARTER_CYC = hub_cfg_pkg::I2C_QUARTER_CYC
) (
	input  wire logic                           mclk,
	input  wire logic                           rst_n,
	input  wire logic                           externalResetN,
	input  wire logic                           supplySourceStrapN,
	input  wire logic                           hostA,
	input  wire logic                           globalOvercurrentN,
	input  wire logic                           hubConfigured,
	input  wire logic                           busActivity,
	input  wire logic                           hubLedChargeStrapIn,
	output logic                                hubLedChargeStrapOut,
	output logic                                hubLedChargeStrapOe,
	input  wire logic                           port1LedEepromClockIn,
	output logic                                port1LedEepromClockOut,
	output logic                                port1LedEepromClockOe,
	input  wire logic                           eepromDataIn,
	output logic                                eepromDataOut,
	output logic                                eepromDataOe,
	output logic                                downstreamPowerEnableN,
	output hub_cfg_pkg::mode_e                  chargeMode,
	output logic                                chargeActive,
	output logic                                suspendActive,
	output logic                                lowPowerReq,
	output logic                                attachReq,
	output logic [15:0]                         vendorId,
	output logic [15:0]                         productId,
	output logic [15:0]                         releaseBcd,
	output logic [7:0]                          nbrPorts,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [hub_cfg_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                    pwdata,
	output logic [31:0]                         prdata,
	output logic                                pready,
	output logic                                pslverr
);
	import hub_cfg_pkg::*;

	logic        rstAll;
	logic        chargeStrap_r;
	logic        selfPowered;
	logic [31:0] ctrl_r;
	logic        reload_r;
	logic [$clog2(IDLE_CYC+1)-1:0]    idleCnt_r;
	logic [$clog2(QUARTER_CYC+1)-1:0] qCnt_r;
	logic        tick;
	logic [1:0]  ph_r;
	i2c_e        iState_r;
	logic [2:0]  bitCnt_r;
	logic [1:0]  wStep_r;
	logic [4:0]  byteCnt_r;
	logic [7:0]  shift_r;
	logic [7:0]  xorAcc_r;
	logic        resNz_r;
	logic        nack_r;
	logic        loadDone_r;
	logic        imageValid_r;
	logic [7:0]  image_r [IMG_BYTES];
	logic [7:0]  txByte;
	logic        apbAccess;
	logic        imgOk;

	assign rstAll    = !rst_n || !externalResetN;
	assign selfPowered = supplySourceStrapN;                                                  // R01
	assign apbAccess = psel && penable && pready;
	assign tick      = (qCnt_r == ($bits(qCnt_r))'(QUARTER_CYC - 1));
	assign txByte    = (wStep_r == 2'd0) ? EEP_DEV_WR : (wStep_r == 2'd1) ? EEP_START : EEP_DEV_RD;
	assign imgOk     = !nack_r && image_r[IMG_CHK0] == CHK0_VAL && image_r[IMG_CHK1] == CHK1_VAL   // R15
	                   && xorAcc_r == image_r[IMG_SUM] && !resNz_r;                               // R16 R17 R24

	// Strap capture while either reset is held
	always_ff @(posedge mclk) begin
		if (rstAll) begin
			chargeStrap_r <= hubLedChargeStrapIn;                                                  // R02 R03
		end
	end

	// Port capability selection
	always_ff @(posedge mclk) begin
		if (rstAll) begin
			chargeMode   <= MODE_SDP;
			chargeActive <= 1'b0;
		end else if (chargeStrap_r && selfPowered && hostA) begin                                  // R10 R22
			chargeMode   <= MODE_CDP;
			chargeActive <= 1'b1;                                                                  // R09
		end else if (chargeStrap_r && selfPowered && !hostA) begin                                 // R11
			chargeMode   <= MODE_DCP;
			chargeActive <= 1'b1;                                                                  // R09
		end else begin
			chargeMode   <= MODE_SDP;                                                              // R12 R13
			chargeActive <= 1'b0;
		end
	end

	// Ganged downstream power
	always_ff @(posedge mclk) begin
		if (rstAll) begin
			downstreamPowerEnableN <= 1'b1;
		end else begin
			downstreamPowerEnableN <= !(hubConfigured && globalOvercurrentN);                        // R04 R05
		end
	end

	// Suspend timing
	always_ff @(posedge mclk) begin
		if (rstAll || busActivity) begin
			idleCnt_r     <= '0;
			suspendActive <= 1'b0;
			lowPowerReq   <= 1'b0;
		end else begin
			if (idleCnt_r != ($bits(idleCnt_r))'(IDLE_CYC)) begin
				idleCnt_r <= idleCnt_r + 1'b1;
			end
			if (idleCnt_r == ($bits(idleCnt_r))'(IDLE_CYC - 1)) begin
				suspendActive <= 1'b1;                                                             // R07
			end
			lowPowerReq <= suspendActive && !selfPowered;                                          // R08
		end
	end

	// Hub activity indicator on the strap pin
	always_ff @(posedge mclk) begin
		if (rstAll) begin
			hubLedChargeStrapOe  <= 1'b0;
			hubLedChargeStrapOut <= 1'b0;
		end else begin
			hubLedChargeStrapOe  <= 1'b1;                                                          // R20
			hubLedChargeStrapOut <= ctrl_r[CTRL_LED_EN] && attachReq && busActivity;               // R20
		end
	end

	// EEPROM bit timing
	always_ff @(posedge mclk) begin
		if (rstAll || iState_r == I_IDLE) begin
			qCnt_r <= '0;
			ph_r   <= 2'd0;
		end else if (tick) begin
			qCnt_r <= '0;
			ph_r   <= ph_r + 2'd1;
		end else begin
			qCnt_r <= qCnt_r + 1'b1;
		end
	end

	// EEPROM image reader
	always_ff @(posedge mclk) begin
		if (rstAll || reload_r) begin
			iState_r <= I_IDLE;
			port1LedEepromClockOe <= 1'b0;
			eepromDataOe <= 1'b0;
			bitCnt_r <= 3'd7;
			wStep_r <= 2'd0;
			byteCnt_r <= 5'd0;
			shift_r <= 8'h00;
			xorAcc_r <= 8'h00;
			resNz_r <= 1'b0;
			nack_r <= 1'b0;
			loadDone_r <= 1'b0;
			imageValid_r <= 1'b0;
			attachReq <= 1'b0;
		end else begin
			case (iState_r)
				I_IDLE: begin
					iState_r <= I_START;
				end
				I_START: begin
					if (tick) begin
						case (ph_r)
							2'd0: eepromDataOe <= 1'b0;
							2'd1: port1LedEepromClockOe <= 1'b0;
							2'd2: eepromDataOe <= 1'b1;
							default: begin
								port1LedEepromClockOe <= 1'b1;
								bitCnt_r <= 3'd7;
								iState_r <= I_WBIT;
							end
						endcase
					end
				end
				I_WBIT, I_RBIT: begin
					if (tick) begin
						case (ph_r)
							2'd0: eepromDataOe <= (iState_r == I_WBIT) && !txByte[bitCnt_r];
							2'd1: port1LedEepromClockOe <= 1'b0;
							2'd2: shift_r <= {shift_r[6:0], eepromDataIn};
							default: begin
								port1LedEepromClockOe <= 1'b1;
								bitCnt_r <= bitCnt_r - 3'd1;
								if (bitCnt_r == 3'd0) begin
									iState_r <= (iState_r == I_WBIT) ? I_WACK : I_RACK;
								end
							end
						endcase
					end
				end
				I_WACK: begin
					if (tick) begin
						case (ph_r)
							2'd0: eepromDataOe <= 1'b0;
							2'd1: port1LedEepromClockOe <= 1'b0;
							2'd2: nack_r <= eepromDataIn;                                          // R24
							default: begin
								port1LedEepromClockOe <= 1'b1;
								wStep_r <= wStep_r + 2'd1;
								if (nack_r) begin
									iState_r <= I_STOP;                                            // R24
								end else if (wStep_r == 2'd1) begin
									iState_r <= I_START;
								end else begin
									iState_r <= (wStep_r == 2'd0) ? I_WBIT : I_RBIT;
								end
							end
						endcase
					end
				end
				I_RACK: begin
					if (tick) begin
						case (ph_r)
							2'd0: eepromDataOe <= (byteCnt_r != IMG_SUM);
							2'd1: port1LedEepromClockOe <= 1'b0;
							2'd2: begin
								image_r[byteCnt_r] <= shift_r;
								if (byteCnt_r != IMG_SUM) begin
									xorAcc_r <= xorAcc_r ^ shift_r;                                // R16
								end
								if (((byteCnt_r >= IMG_RSV0_LO && byteCnt_r <= IMG_RSV0_HI)
								     || (byteCnt_r >= IMG_RSV1_LO && byteCnt_r <= IMG_RSV1_HI))
								    && shift_r != 8'h00) begin
									resNz_r <= 1'b1;                                               // R17
								end
							end
							default: begin
								port1LedEepromClockOe <= 1'b1;
								byteCnt_r <= byteCnt_r + 5'd1;
								iState_r <= (byteCnt_r == IMG_SUM) ? I_STOP : I_RBIT;
							end
						endcase
					end
				end
				I_STOP: begin
					if (tick) begin
						case (ph_r)
							2'd0: eepromDataOe <= 1'b1;
							2'd1: port1LedEepromClockOe <= 1'b0;
							2'd2: eepromDataOe <= 1'b0;
							default: iState_r <= I_DONE;
						endcase
					end
				end
				default: begin
					loadDone_r   <= 1'b1;
					imageValid_r <= imgOk;                                                         // R15 R16 R17
					attachReq    <= loadDone_r;                                                    // R23
				end
			endcase
		end
	end

	// Descriptor fields
	always_ff @(posedge mclk) begin
		if (rstAll || !loadDone_r || !imageValid_r) begin
			vendorId   <= DEF_VID;                                                                 // R17
			productId  <= DEF_PID;
			releaseBcd <= DEF_REL;
			nbrPorts   <= DEF_PORTS;
		end else begin
			vendorId   <= {image_r[IMG_VID + 5'd1], image_r[IMG_VID]};                             // R18
			productId  <= {image_r[IMG_PID + 5'd1], image_r[IMG_PID]};                             // R18
			releaseBcd <= {image_r[IMG_REL + 5'd1], image_r[IMG_REL]};                             // R18
			nbrPorts   <= image_r[IMG_PORTS];                                                      // R19
		end
	end

	// Fixed lines of the open-drain pins
	always_ff @(posedge mclk) begin
		port1LedEepromClockOut <= 1'b0;
		eepromDataOut          <= 1'b0;
	end

	// APB slave, one wait state
	always_ff @(posedge mclk) begin
		if (rstAll) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (psel && penable && !pready) begin
				if (paddr == OFS_STAT) begin
					prdata[STAT_MODE +: 2] <= chargeMode;
					prdata[STAT_CHRG]      <= chargeStrap_r;
					prdata[STAT_SELF]      <= selfPowered;
					prdata[STAT_HOST]      <= hostA;
					prdata[STAT_LOADED]    <= loadDone_r;
					prdata[STAT_VALID]     <= imageValid_r;
					prdata[STAT_NACK]      <= nack_r;
					prdata[STAT_SUSP]      <= suspendActive;
					prdata[STAT_LOWPWR]    <= lowPowerReq;
					prdata[STAT_PWREN_N]   <= downstreamPowerEnableN;
				end else if (paddr == OFS_CTRL) begin
					prdata <= ctrl_r;
				end else if (paddr == OFS_IDS) begin
					prdata <= {productId, vendorId};
				end else if (paddr == OFS_INFO) begin
					prdata <= {NUM_ENDPOINTS, NUM_CONFIGS, nbrPorts, 8'h00} | {16'h0000, releaseBcd}; // R14
				end else begin
					pslverr <= 1'b1;
				end
			end
		end
	end

	// Control register
	always_ff @(posedge mclk) begin
		if (rstAll) begin
			ctrl_r   <= CTRL_RESET;
			reload_r <= 1'b0;
		end else begin
			reload_r <= apbAccess && pwrite && paddr == OFS_CTRL && pwdata[CTRL_RELOAD];
			if (apbAccess && pwrite && paddr == OFS_CTRL) begin
				ctrl_r <= {31'h0000_0000, pwdata[CTRL_LED_EN]};
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rstAll);

	AST_PWR_ON: assert property (hubConfigured && globalOvercurrentN |=> !downstreamPowerEnableN) // R04
		else $error("power enable not asserted while configured");
	AST_PWR_OVC: assert property (!globalOvercurrentN |=> downstreamPowerEnableN) // R05
		else $error("power enable asserted during overcurrent");
	AST_CDP: assert property (chargeStrap_r && supplySourceStrapN && hostA |=> chargeMode == MODE_CDP) // R10
		else $error("CDP mode not selected");
	AST_DCP: assert property (chargeStrap_r && supplySourceStrapN && !hostA |=> chargeMode == MODE_DCP) // R11
		else $error("DCP mode not selected");
	AST_SDP_BUS: assert property (!supplySourceStrapN && hostA |=> chargeMode == MODE_SDP && !chargeActive) // R12
		else $error("charging while bus powered");
	AST_SDP_NOCHG: assert property (!chargeStrap_r && hostA |=> chargeMode == MODE_SDP) // R13
		else $error("charging with strap low");
	AST_CHG_SUSP: assert property (chargeStrap_r && supplySourceStrapN && suspendActive |=> chargeActive) // R09
		else $error("charging dropped in suspend");
	AST_SUSP_IDLE: assert property ($rose(suspendActive) |-> idleCnt_r == ($bits(idleCnt_r))'(IDLE_CYC)) // R07
		else $error("suspend entered early");
	AST_LOWPWR: assert property (suspendActive && !supplySourceStrapN && !busActivity |=> lowPowerReq) // R08
		else $error("low power not requested");
	AST_VALID: assert property (imageValid_r |-> image_r[IMG_CHK0] == CHK0_VAL && image_r[IMG_CHK1] == CHK1_VAL
	                            && !resNz_r && xorAcc_r == image_r[IMG_SUM]) // R15
		else $error("invalid image accepted");
	AST_NACK: assert property (nack_r |-> !imageValid_r) // R24
		else $error("unacknowledged EEPROM accepted");
	AST_DEFAULT: assert property (loadDone_r && !imageValid_r |=> vendorId == DEF_VID && nbrPorts == DEF_PORTS) // R17
		else $error("defaults not used");
	AST_ATTACH: assert property (attachReq |-> loadDone_r) // R23
		else $error("attach before image load");
	AST_STRAP: assert property (@(posedge mclk) disable iff (1'b0) // R03
	                            rstAll |=> chargeStrap_r == $past(hubLedChargeStrapIn))
		else $error("charge strap not latched in reset");

	COV_CDP: cover property (chargeMode == MODE_CDP);
	COV_DCP: cover property (chargeMode == MODE_DCP);
	COV_IMG_OK: cover property ($rose(imageValid_r));
	COV_SUSPEND: cover property ($rose(lowPowerReq));
endmodule : usb_hub_cfg_power

/* tb/eeprom_model.sv */
`timescale 1ns/100ps
module eeprom_model
	import hub_cfg_pkg::*;
(
	input  wire logic         scl,
	input  wire logic         sda,
	input  wire logic [255:0] image,
	input  wire logic         ackEn,
	output logic              sdaPull
);
	logic       active   = 0;
	logic       addrByte = 0;
	logic       txByte   = 0;
	logic       slaveAck = 0;
	logic [7:0] sr       = 0;
	logic [4:0] ptr      = 0;
	int         cnt      = 0;
	initial sdaPull = 0;
	// Start or repeated start
	always @(negedge sda) begin
		if (scl) begin
			active = 1;
			addrByte = 1;
			txByte = 0;
			cnt = 0;
		end
	end
	// Stop
	always @(posedge sda) begin
		if (scl) active = 0;
	end
	always @(posedge scl) begin
		if (active && cnt < 8) begin
			sr = {sr[6:0], sda};
			cnt++;
			if (cnt == 8) slaveAck = !txByte && (!addrByte || (ackEn && sr[7:1] == EEP_DEV_WR[7:1]));
			if (cnt == 8 && !txByte && !addrByte) ptr = sr[4:0];
		end else if (active) begin
			cnt = 0;
			if (txByte && sda) active = 0;
			if (txByte) ptr++;
			if (addrByte) txByte = sr[0] && slaveAck;
			if (addrByte && !slaveAck) active = 0;
			addrByte = 0;
		end
	end
	// Released data line goes to the pull-up level
	always @(negedge scl) begin
		if (!active) sdaPull <= 0;
		else if (cnt == 8) sdaPull <= slaveAck;
		else sdaPull <= txByte && !image[8 * ptr + 7 - cnt];
	end
endmodule : eeprom_model

/* tb/usb_hub_config_and_port_power_tb_top.sv */
`timescale 1ns/100ps
module usb_hub_config_and_port_power_tb_top;
	import hub_cfg_pkg::*;
	localparam int IDLE = 50;
	logic         mclk = 0, rst_n = 0, extRstN = 1, supplyN = 1, hostA = 1, ovcN = 1, cfgd = 0, busAct = 0;
	logic         strap = 1, ackEn = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic         ledOut, ledOe, sclOe, sdaOe, sdaPull, pwrEnN, chgAct, susp, lowPwr, attach;
	mode_e        mode;
	logic [15:0]  vid, pid, rel;
	logic [7:0]   ports, paddr = 0;
	logic [31:0]  pwdata = 0, prdata, rd, st;
	logic [255:0] image;
	int           fails = 0, checksDone = 0;
	wire          ledLine = (ledOe === 1'b1) ? ledOut : strap;
	wire          sclLine = !sclOe;
	wire          sdaLine = !(sdaOe || sdaPull);

	usb_hub_cfg_power #(.IDLE_CYC(IDLE), .QUARTER_CYC(2)) i_dut (
		.mclk(mclk), .rst_n(rst_n), .externalResetN(extRstN), .supplySourceStrapN(supplyN),
		.hostA(hostA), .globalOvercurrentN(ovcN), .hubConfigured(cfgd), .busActivity(busAct),
		.hubLedChargeStrapIn(ledLine), .hubLedChargeStrapOut(ledOut), .hubLedChargeStrapOe(ledOe),
		.port1LedEepromClockIn(sclLine), .port1LedEepromClockOut(), .port1LedEepromClockOe(sclOe),
		.eepromDataIn(sdaLine), .eepromDataOut(), .eepromDataOe(sdaOe),
		.downstreamPowerEnableN(pwrEnN), .chargeMode(mode), .chargeActive(chgAct), .suspendActive(susp),
		.lowPowerReq(lowPwr), .attachReq(attach), .vendorId(vid), .productId(pid), .releaseBcd(rel),
		.nbrPorts(ports), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));

	eeprom_model i_eep (.scl(sclLine), .sda(sdaLine), .image(image), .ackEn(ackEn), .sdaPull(sdaPull));

	initial begin
		forever #5 mclk = ~mclk;
	end

	task automatic final_report;
		if (fails == 0 && checksDone > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checksDone++;
		if (got !== exp) begin
			$display("FAIL %0t %s", $time, msg);
			fails++;
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		chk(n < 20, 1, "apb hang");
		@(posedge mclk);
	endtask : apb

	function automatic logic [255:0] mkImg(input int kind);
		logic [255:0] m;
		logic [7:0]   s;
		m = '0;
		m[63:0] = {16'h0217, 16'h9876, 16'hABCD, CHK1_VAL, CHK0_VAL};
		m[8*26+:8] = 8'h03;
		if (kind == 1) m[7:0] = 8'h41;
		if (kind == 2) m[15:8] = 8'h1B;
		if (kind == 3) m[8*16+:8] = 8'h01;
		if (kind == 4) m[8*28+:8] = 8'h01;
		s = 0;
		for (int i = 0; i < 31; i++) s ^= m[8*i+:8];
		m[8*31+:8] = (kind == 5) ? ~s : s;
		return m;
	endfunction : mkImg

	task automatic doReset(input logic ext, input logic s);
		int n;
		strap <= s;
		if (ext) extRstN <= 0;
		else rst_n <= 0;
		cyc(ext ? 1000 : 5);
		chk(ledOe, 0, "strap pin driven in reset");
		chk(pwrEnN, 1, "power on in reset");
		extRstN <= 1;
		rst_n <= 1;
		n = 0;
		while (attach !== 1'b1 && n < 4000) begin
			@(posedge mclk);
			n++;
		end
		chk(n > 2000 && n < 4000, 1, "attach timing");
	endtask : doReset

	task automatic tLoad;
		chk({vid, pid, rel, ports}, {16'hABCD, 16'h9876, 16'h0217, 8'h03}, "image ids");
		apb(0, OFS_IDS, 0);
		chk(rd, 32'h9876ABCD, "ids register");
		apb(0, OFS_STAT, 0);
		chk(rd[STAT_VALID:STAT_LOADED], 2'b11, "image not valid");
	endtask : tLoad

	task automatic tLed;
		busAct <= 1;
		cyc(3);
		chk({ledOe, ledLine}, 2'b11, "no activity led");
		busAct <= 0;
		cyc(3);
		chk(ledLine, 0, "led stuck");
		apb(1, OFS_CTRL, 0);
		busAct <= 1;
		cyc(3);
		chk(ledLine, 0, "led not disabled");
		apb(1, OFS_CTRL, 1);
	endtask : tLed

	task automatic tPwr;
		for (int c = 0; c < 2; c++) begin
			for (int o = 0; o < 2; o++) begin
				cfgd <= c[0];
				ovcN <= o[0];
				cyc(3);
				chk(pwrEnN, !(c[0] && o[0]), "power enable");
			end
		end
	endtask : tPwr

	task automatic tApb;
		apb(0, OFS_INFO, 0);
		chk(rd[31:16], 16'h0201, "configs and endpoints");
		apb(0, OFS_CTRL, 0);
		chk(rd, 32'h1, "ctrl reset value");
		apb(0, OFS_STAT, 0);
		st = rd;
		apb(1, OFS_STAT, 32'hFFFFFFFF);
		apb(0, OFS_STAT, 0);
		chk(rd, st, "status written");
		apb(0, 8'h10, 0);
		chk({err, rd}, {1'b1, 32'h0}, "unmapped address");
	endtask : tApb

	task automatic live(input logic h, input logic s, input mode_e exp);
		hostA <= h;
		supplyN <= s;
		cyc(3);
		chk({chgAct, mode}, {exp != MODE_SDP, exp}, "charge mode");
	endtask : live

	task automatic tCharge;
		doReset(0, 0);
		live(1, 1, MODE_SDP);
		live(1, 0, MODE_SDP);
		doReset(1, 1);
		live(1, 1, MODE_CDP);
		live(0, 1, MODE_DCP);
		live(1, 0, MODE_SDP);
		live(1, 1, MODE_CDP);
	endtask : tCharge

	task automatic tSuspend;
		busAct <= 1;
		cyc(2);
		busAct <= 0;
		cyc(IDLE - 5);
		chk(susp, 0, "early suspend");
		cyc(10);
		chk({susp, chgAct, lowPwr}, 3'b110, "suspend self powered");
		supplyN <= 0;
		cyc(3);
		chk(lowPwr, 1, "no low power");
		busAct <= 1;
		cyc(2);
		chk(susp, 0, "suspend kept");
		supplyN <= 1;
	endtask : tSuspend

	task automatic tBad;
		for (int k = 1; k < 7; k++) begin
			image <= mkImg(k == 6 ? 0 : k);
			ackEn <= (k != 6);
			apb(1, OFS_CTRL, 32'h3);
			cyc(3000);
			chk({vid, pid, rel, ports}, {DEF_VID, DEF_PID, DEF_REL, DEF_PORTS}, "defaults");
			apb(0, OFS_STAT, 0);
			chk(rd[STAT_NACK:STAT_VALID], {k == 6, 1'b0}, "bad image status");
		end
	endtask : tBad

	initial begin
		#(100000 * 10);
		fails++;
		final_report;
	end

	initial begin
		image = mkImg(0);
		doReset(0, 1);
		tLoad;
		tLed;
		tPwr;
		tApb;
		tCharge;
		tSuspend;
		tBad;
		final_report;
	end
endmodule : usb_hub_config_and_port_power_tb_top
